/* File: etsf_ep0_status.sv */
// Endpoint 0 transmit status, FIFO flags and receive data port
// Summary of operation
// - Setup success sets data toggle; each good IN data stage inverts it.
// - Toggle 0 sends DATA0 PID, toggle 1 sends DATA1 PID next.
// - Data toggle is read-only to software and zero after reset.
// - Status stage sets stage flag; next setup start clears it.
// - Stall status set at IN end when STALL was answered.
// - Stall control set means every valid IN gets STALL.
// - No-ack status set at IN end when NACK was answered.
// - Valid IN gets NACK when no transmit data is ready.
// - Error status set at IN end when any transfer error occurred.
// - Stall, no-ack, error refresh at every IN end; software cannot write.
// - Host-acked data sets ack status and the transmit interrupt bit.
// - Software clears ack by writing 0 to it; setup start also clears it.
// - Empty flag high while transmit FIFO empty; set after reset.
// - Full flag high while transmit FIFO full; zero after reset.
// - Transmit read of empty FIFO sets under-run and interrupt bit.
// - Software write to full FIFO sets over-run and interrupt bit.
// - Completed FIFO clear drops under-run, over-run and interrupt bit.
// - Receive FIFO delivers one byte per read of its data port.
// - Clear bit resets pointers, sets empty, clears flags, self-clears.
`timescale 1ns/1ps
module etsf_ep0_status
    import etsf_pkg::*;
(
    input  wire logic                   CLK,
    input  wire logic                   RST_N,
    input  wire logic                   WB_CYC_I,
    input  wire logic                   WB_STB_I,
    input  wire logic                   WB_WE_I,
    input  wire logic [7:0]             WB_ADR_I,
    input  wire logic [3:0]             WB_SEL_I,
    input  wire logic [31:0]            WB_DAT_I,
    output logic      [31:0]            WB_DAT_O,
    output logic                        WB_ACK_O,
    input  wire logic                   SETUP_BEGIN,
    input  wire logic                   SETUP_DONE,
    input  wire logic                   STATUS_STAGE,
    input  wire logic                   IN_TOKEN,
    input  wire logic                   IN_DONE,
    input  wire logic                   IN_HOST_ACK,
    input  wire logic                   IN_ERROR,
    output etsf_resp_t                  IN_RESP,
    output logic                        IN_PID_DATA1,
    input  wire logic                   TX_RD,
    output logic      [ETSF_FIFO_W-1:0] TX_RD_DATA,
    input  wire logic                   RX_WR,
    input  wire logic [ETSF_FIFO_W-1:0] RX_WR_DATA,
    output logic                        RX_FULL,
    output logic                        EP0_TX_INT
);
    import etsf_pkg::*;

    // Bus side state
    logic        ack_r;
    logic [31:0] dat_r;

    // Status and control state
    logic       toggle_r;
    logic       stage_r;
    logic       stall_st_r;
    logic       nack_st_r;
    logic       err_st_r;
    logic       ack_st_r;
    logic       tx_fifo_underrun_flag_r;
    logic       tx_fifo_overrun_flag_r;
    logic       txint_r;
    logic       clr_r;
    logic       stall_ctl_r;
    etsf_resp_t resp_r;
    logic       pid_r;
    logic [7:0] txrd_r;
    logic       rxfull_r;

    // FIFO status
    wire                   tx_empty;
    wire                   tx_full;
    wire                   rx_full;
    wire [ETSF_FIFO_W-1:0] tx_head;
    wire [ETSF_FIFO_W-1:0] rx_head;

    // Word-aligned decode helper (address bits 1:0 ignored), used for every register hit
    function automatic logic hit(input logic [7:0] adr,
                                 input logic [7:0] ofs);
        hit = (adr[7:2] == ofs[7:2]);
    endfunction : hit

    // Wishbone request decode; one access per request, ack a cycle later
    wire bus_req   = WB_CYC_I && WB_STB_I && !ack_r;
    wire bus_wr    = bus_req && WB_WE_I && WB_SEL_I[0];
    wire bus_rd    = bus_req && !WB_WE_I;
    wire wr_status = bus_wr && hit(WB_ADR_I, ETSF_OFS_TX_STATUS);
    wire wr_ctrl   = bus_wr && hit(WB_ADR_I, ETSF_OFS_TX_CTRL);
    wire wr_txdata = bus_wr && hit(WB_ADR_I, ETSF_OFS_TX_DATA);
    wire rd_rxdata = bus_rd && hit(WB_ADR_I, ETSF_OFS_RX_DATA);

    // Transaction results at the end of an IN, FIFO under-run and over-run events, software ack clear
    wire in_was_data  = (resp_r == ETSF_RESP_DATA);
    wire data_ok      = IN_DONE && in_was_data && IN_HOST_ACK && !IN_ERROR;
    wire tx_fifo_underrun_flag_set     = TX_RD && tx_empty;
    wire tx_fifo_overrun_flag_set     = wr_txdata && tx_full;
    wire int_set      = data_ok || tx_fifo_underrun_flag_set || tx_fifo_overrun_flag_set;
    wire ack_clr_sw   = wr_status && !WB_DAT_I[ETSF_ST_ACK];

    // Answer for an IN token: stall beats nack beats data
    wire etsf_resp_t resp_nxt =
        stall_ctl_r ? ETSF_RESP_STALL :
        tx_empty    ? ETSF_RESP_NACK  :
                      ETSF_RESP_DATA;

    // Register read mux; reserved bits are tied to zero
    wire [7:0] st_byte = {toggle_r, 2'b00, stage_r, stall_st_r,
                          nack_st_r, err_st_r, ack_st_r};
    wire [7:0] fl_byte = {4'h0, tx_empty, tx_full,
                          tx_fifo_underrun_flag_r, tx_fifo_overrun_flag_r};
    wire [7:0] ct_byte = {clr_r, 3'b000, stall_ctl_r, 3'b000};
    wire [7:0] is_byte = {7'h00, txint_r};
    wire [7:0] rd_byte =
        hit(WB_ADR_I, ETSF_OFS_TX_STATUS) ? st_byte :
        hit(WB_ADR_I, ETSF_OFS_TX_FLAGS)  ? fl_byte :
        hit(WB_ADR_I, ETSF_OFS_RX_DATA)   ? rx_head :
        hit(WB_ADR_I, ETSF_OFS_TX_CTRL)   ? ct_byte :
        hit(WB_ADR_I, ETSF_OFS_INT_STAT)  ? is_byte : 8'h00;

    // Next values of the status bits
    wire toggle_nxt = SETUP_DONE ? 1'b1 :
                      data_ok    ? !toggle_r : toggle_r;
    wire stage_nxt  = STATUS_STAGE ? 1'b1 :
                      SETUP_BEGIN  ? 1'b0 : stage_r;
    wire ack_nxt    = data_ok     ? 1'b1 :
                      SETUP_BEGIN ? 1'b0 :
                      ack_clr_sw  ? 1'b0 : ack_st_r;
    wire tx_fifo_underrun_flag_nxt   = tx_fifo_underrun_flag_set ? 1'b1 : clr_r ? 1'b0 : tx_fifo_underrun_flag_r;
    wire tx_fifo_overrun_flag_nxt   = tx_fifo_overrun_flag_set ? 1'b1 : clr_r ? 1'b0 : tx_fifo_overrun_flag_r;
    wire txint_nxt  = int_set ? 1'b1 :
                      (clr_r || ack_clr_sw) ? 1'b0 : txint_r;
    wire clr_nxt    = wr_ctrl && WB_DAT_I[ETSF_CT_CLEAR];
    wire stl_nxt    = wr_ctrl     ? WB_DAT_I[ETSF_CT_STALL] :
                      SETUP_DONE  ? 1'b0 : stall_ctl_r;

    // Transmit FIFO, filled by software, drained by the transmit logic
    etsf_byte_fifo u_tx_fifo (
        .clk   (CLK),
        .rst_n (RST_N),
        .clr   (clr_r),
        .wr    (wr_txdata),
        .wdata (WB_DAT_I[7:0]),
        .rd    (TX_RD),
        .rdata (tx_head),
        .empty (tx_empty),
        .full  (tx_full)
    );

    // Receive FIFO, filled by the USB side, drained a byte per read
    etsf_byte_fifo u_rx_fifo (
        .clk   (CLK),
        .rst_n (RST_N),
        .clr   (1'b0),
        .wr    (RX_WR),
        .wdata (RX_WR_DATA),
        .rd    (rd_rxdata),
        .rdata (rx_head),
        .empty (),
        .full  (rx_full)
    );

    // Bus answer; unmapped reads return zero, unmapped writes are dropped
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= bus_req;
            dat_r <= bus_rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // Status bits; an event in the cycle of a clear always wins
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            toggle_r   <= ETSF_RST_TOGGLE;
            stage_r    <= ETSF_RST_BIT;
            ack_st_r   <= ETSF_RST_BIT;
            tx_fifo_underrun_flag_r     <= ETSF_RST_BIT;
            tx_fifo_overrun_flag_r     <= ETSF_RST_BIT;
            txint_r    <= ETSF_RST_BIT;
        end else begin
            toggle_r   <= toggle_nxt;
            stage_r    <= stage_nxt;
            ack_st_r   <= ack_nxt;
            tx_fifo_underrun_flag_r     <= tx_fifo_underrun_flag_nxt;
            tx_fifo_overrun_flag_r     <= tx_fifo_overrun_flag_nxt;
            txint_r    <= txint_nxt;
        end
    end

    // Handshake results refresh at each IN end and never by software
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            stall_st_r <= ETSF_RST_BIT;
            nack_st_r  <= ETSF_RST_BIT;
            err_st_r   <= ETSF_RST_BIT;
        end else if (IN_DONE) begin
            stall_st_r <= (resp_r == ETSF_RESP_STALL);
            nack_st_r  <= (resp_r == ETSF_RESP_NACK);
            err_st_r   <= IN_ERROR;
        end
    end

    // Control bits; the clear bit lives for exactly one cycle
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            clr_r       <= ETSF_RST_BIT;
            stall_ctl_r <= ETSF_RST_BIT;
        end else begin
            clr_r       <= clr_nxt;
            stall_ctl_r <= stl_nxt;
        end
    end

    // IN answer and PID latched at the token so they hold for the packet
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            resp_r <= ETSF_RESP_NACK;
            pid_r  <= ETSF_PID_DATA0;
        end else if (IN_TOKEN) begin
            resp_r <= resp_nxt;
            pid_r  <= toggle_r ? ETSF_PID_DATA1 : ETSF_PID_DATA0;
        end
    end

    // Transmit byte goes out registered; an empty read returns zero
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            txrd_r   <= 8'h00;
            rxfull_r <= 1'b0;
        end else begin
            txrd_r   <= TX_RD ? (tx_empty ? 8'h00 : tx_head) : txrd_r;
            rxfull_r <= rx_full;
        end
    end

    assign WB_ACK_O     = ack_r;
    assign WB_DAT_O     = dat_r;
    assign IN_RESP      = resp_r;
    assign IN_PID_DATA1 = pid_r;
    assign TX_RD_DATA   = txrd_r;
    assign RX_FULL      = rxfull_r;
    assign EP0_TX_INT   = txint_r;

    // Checks on toggle, answer choice and flag behaviour
    a_toggle_setup: assert property (
        @(posedge CLK) disable iff (!RST_N)
        SETUP_DONE |=> toggle_r)
        else $error("toggle not set after setup");

    a_toggle_flip: assert property (
        @(posedge CLK) disable iff (!RST_N)
        data_ok && !SETUP_DONE |=> toggle_r != $past(toggle_r))
        else $error("toggle not inverted after good IN");

    a_pid_select: assert property (
        @(posedge CLK) disable iff (!RST_N)
        IN_TOKEN |=> IN_PID_DATA1 == $past(toggle_r))
        else $error("data PID does not follow toggle");

    a_stall_answer: assert property (
        @(posedge CLK) disable iff (!RST_N)
        IN_TOKEN && stall_ctl_r |=> IN_RESP == ETSF_RESP_STALL)
        else $error("stall control not answered with STALL");

    a_nack_answer: assert property (
        @(posedge CLK) disable iff (!RST_N)
        IN_TOKEN && !stall_ctl_r && tx_empty
        |=> IN_RESP == ETSF_RESP_NACK)
        else $error("empty FIFO not answered with NACK");

    a_result_bits: assert property (
        @(posedge CLK) disable iff (!RST_N)
        IN_DONE |=> stall_st_r == ($past(resp_r) == ETSF_RESP_STALL)
                 && nack_st_r == ($past(resp_r) == ETSF_RESP_NACK)
                 && err_st_r == $past(IN_ERROR))
        else $error("IN result bits not refreshed");

    a_ack_int: assert property (
        @(posedge CLK) disable iff (!RST_N)
        data_ok |=> ack_st_r && EP0_TX_INT)
        else $error("host ack did not set ack and interrupt");

    a_overrun_set: assert property (
        @(posedge CLK) disable iff (!RST_N)
        tx_fifo_overrun_flag_set |=> (tx_fifo_overrun_flag_r && EP0_TX_INT) [*2])
        else $error("overrun flag or interrupt missing");

    // A clear in the same cycle must not hide the under-run
    a_underrun_set: assert property (
        @(posedge CLK) disable iff (!RST_N)
        tx_fifo_underrun_flag_set |=> tx_fifo_underrun_flag_r && EP0_TX_INT)
        else $error("underrun flag or interrupt missing");

    a_clear_auto: assert property (
        @(posedge CLK) disable iff (!RST_N)
        clr_r && !wr_ctrl ##0 !tx_fifo_underrun_flag_set && !tx_fifo_overrun_flag_set && !int_set
        |=> !clr_r && tx_empty && !tx_fifo_underrun_flag_r && !tx_fifo_overrun_flag_r)
        else $error("FIFO clear did not complete");

    // Checks on clears, flags that hold and the receive port
    a_stage_set: assert property (
        @(posedge CLK) disable iff (!RST_N)
        STATUS_STAGE |=> stage_r)
        else $error("status stage flag not set");

    a_stage_clear: assert property (
        @(posedge CLK) disable iff (!RST_N)
        SETUP_BEGIN && !STATUS_STAGE |=> !stage_r)
        else $error("status stage flag not cleared by setup");

    a_ack_clear: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (SETUP_BEGIN || ack_clr_sw) && !data_ok |=> !ack_st_r)
        else $error("ack status not cleared");

    a_toggle_ro: assert property (
        @(posedge CLK) disable iff (!RST_N)
        wr_status && !SETUP_DONE && !data_ok |=> $stable(toggle_r))
        else $error("software changed the data toggle");

    a_full_hold: assert property (
        @(posedge CLK) disable iff (!RST_N)
        tx_full && !TX_RD && !clr_r |=> tx_full)
        else $error("full flag dropped without a read");

    a_clear_int: assert property (
        @(posedge CLK) disable iff (!RST_N)
        clr_r && !int_set |=> !EP0_TX_INT && !tx_fifo_underrun_flag_r && !tx_fifo_overrun_flag_r)
        else $error("FIFO clear left a flag or interrupt set");

    a_empty_clear: assert property (
        @(posedge CLK) disable iff (!RST_N)
        clr_r |=> tx_empty && !tx_full)
        else $error("FIFO clear did not leave it empty");

    a_rx_read: assert property (
        @(posedge CLK) disable iff (!RST_N)
        rd_rxdata |=> WB_DAT_O == {24'h00_0000, $past(rx_head)})
        else $error("receive byte not returned on read");

    a_tx_fifo_underrun_flag_hold: assert property (
        @(posedge CLK) disable iff (!RST_N)
        tx_fifo_underrun_flag_r && !clr_r |=> tx_fifo_underrun_flag_r)
        else $error("underrun flag dropped before a clear");

endmodule : etsf_ep0_status

/* File: etsf_pkg.sv */
// Shared constants and types of the endpoint 0 transmit status block
package etsf_pkg;

    // Register byte offsets on the Wishbone bus
    localparam logic [7:0] ETSF_OFS_TX_STATUS = 8'h00;
    localparam logic [7:0] ETSF_OFS_TX_FLAGS  = 8'h04;
    localparam logic [7:0] ETSF_OFS_RX_DATA   = 8'h08;
    localparam logic [7:0] ETSF_OFS_TX_CTRL   = 8'h0C;
    localparam logic [7:0] ETSF_OFS_TX_DATA   = 8'h10;
    localparam logic [7:0] ETSF_OFS_INT_STAT  = 8'h14;

    // Transmit status field positions
    localparam int ETSF_ST_TOGGLE = 7;
    localparam int ETSF_ST_STAGE  = 4;
    localparam int ETSF_ST_STALL  = 3;
    localparam int ETSF_ST_NACK   = 2;
    localparam int ETSF_ST_ERROR  = 1;
    localparam int ETSF_ST_ACK    = 0;

    // Transmit FIFO flag positions
    localparam int ETSF_FL_EMPTY = 3;
    localparam int ETSF_FL_FULL  = 2;
    localparam int ETSF_FL_TX_FIFO_UNDERRUN_FLAG  = 1;
    localparam int ETSF_FL_TX_FIFO_OVERRUN_FLAG  = 0;

    // Transmit control field positions
    localparam int ETSF_CT_CLEAR = 7;
    localparam int ETSF_CT_STALL = 3;

    // Interrupt status field position
    localparam int ETSF_IS_TXINT = 0;

    // Reset values
    localparam logic ETSF_RST_TOGGLE = 1'b0;
    localparam logic ETSF_RST_EMPTY  = 1'b1;
    localparam logic ETSF_RST_BIT    = 1'b0;

    // FIFO geometry
    localparam int ETSF_FIFO_W  = 8;
    localparam int ETSF_FIFO_D  = 8;
    localparam int ETSF_FIFO_AW = 3;

    // Data PID select: value of the PID select output
    localparam logic ETSF_PID_DATA0 = 1'b0;
    localparam logic ETSF_PID_DATA1 = 1'b1;

    // Answer chosen for an IN token, one-hot
    typedef enum logic [2:0] {
        ETSF_RESP_DATA  = 3'b001,
        ETSF_RESP_NACK  = 3'b010,
        ETSF_RESP_STALL = 3'b100
    } etsf_resp_t;

endpackage : etsf_pkg

/* File: etsf_byte_fifo.sv */
// Byte FIFO with synchronous clear, used for transmit and receive data
`timescale 1ns/1ps
module etsf_byte_fifo
    import etsf_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   clr,
    input  wire logic                   wr,
    input  wire logic [ETSF_FIFO_W-1:0] wdata,
    input  wire logic                   rd,
    output logic      [ETSF_FIFO_W-1:0] rdata,
    output logic                        empty,
    output logic                        full
);

    logic [ETSF_FIFO_W-1:0]  mem [ETSF_FIFO_D];
    logic [ETSF_FIFO_AW-1:0] wp_r;
    logic [ETSF_FIFO_AW-1:0] rp_r;
    logic [ETSF_FIFO_AW:0]   cnt_r;
    wire                     do_wr;
    wire                     do_rd;

    // Writes to a full FIFO and reads from an empty one are dropped
    assign do_wr = wr && !full && !clr;
    assign do_rd = rd && !empty && !clr;
    assign empty = (cnt_r == '0);
    assign full  = (cnt_r == (ETSF_FIFO_AW+1)'(ETSF_FIFO_D));
    assign rdata = mem[rp_r];

    // Storage needs no reset; the pointers decide what is valid
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wp_r] <= wdata;
        end
    end

    // Pointers and fill count; clear wins over any access
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else if (clr) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= do_wr ? wp_r + 1'b1 : wp_r;
            rp_r  <= do_rd ? rp_r + 1'b1 : rp_r;
            cnt_r <= cnt_r + {{ETSF_FIFO_AW{1'b0}}, do_wr}
                           - {{ETSF_FIFO_AW{1'b0}}, do_rd};
        end
    end

endmodule : etsf_byte_fifo

/* File: etsf_host_model.sv */
// USB host model that drives control transfers into endpoint 0
`timescale 1ns/1ps
module etsf_host_model
    import etsf_pkg::*;
(
    input  wire logic       clk,
    input  wire etsf_resp_t in_resp,
    input  wire logic       in_pid_data1,
    output logic            setup_begin,
    output logic            setup_done,
    output logic            status_stage,
    output logic            in_token,
    output logic            in_done,
    output logic            in_host_ack,
    output logic            in_error
);
    // Idle lines start quiet so the device sees no stray event
    initial begin
        setup_begin  = 1'b0;
        setup_done   = 1'b0;
        status_stage = 1'b0;
        in_token     = 1'b0;
        in_done      = 1'b0;
        in_host_ack  = 1'b0;
        in_error     = 1'b0;
    end

    // Setup stage: start pulse, then success pulse
    task automatic setup_txn();
        @(posedge clk) setup_begin <= 1'b1;
        @(posedge clk) begin
            setup_begin <= 1'b0;
            setup_done  <= 1'b1;
        end
        @(posedge clk) setup_done <= 1'b0;
    endtask : setup_txn

    // Status stage detected by the function logic
    task automatic stage_txn();
        @(posedge clk) status_stage <= 1'b1;
        @(posedge clk) status_stage <= 1'b0;
    endtask : stage_txn

    // Token first; the answer is taken one cycle after it
    task automatic in_start(output etsf_resp_t resp, output logic pid);
        @(posedge clk) in_token <= 1'b1;
        @(posedge clk) in_token <= 1'b0;
        @(posedge clk);
        resp = in_resp;
        pid  = in_pid_data1;
    endtask : in_start

    // End of IN; ack and error levels are garbage outside the pulse
    task automatic in_end(input logic ack, input logic err);
        @(posedge clk) begin
            in_done     <= 1'b1;
            in_host_ack <= ack;
            in_error    <= err;
        end
        @(posedge clk) begin
            in_done     <= 1'b0;
            in_host_ack <= ~ack;
            in_error    <= ~err;
        end
    endtask : in_end

endmodule : etsf_host_model

/* File: test_etsf_ep0_status.sv */
// Self-checking bench of the endpoint 0 status block with a reference model
`timescale 1ns/1ps
module test_etsf_ep0_status;
    import etsf_pkg::*;

    logic CLK, RST_N, CYC, STB, WE, TX_RD, RX_WR;
    logic [7:0] ADR, RX_WR_DATA, TX_RD_DATA;
    logic [3:0] SEL;
    logic [31:0] DAT_I, DAT_O, dummy;
    logic ACK, SB, SD, SS, TOK, DONE, HACK, HERR, PID1, RXF, INT;
    etsf_resp_t RESP;
    int n_fail = 0, num_checks = 0;
    int tog, stage, stl, nak, er, ak, irq, under, over, stall_ctl;
    logic [7:0] txq[$], rxq[$];
    logic [31:0] seed = 32'hEFE09386;

    etsf_ep0_status i_dut (.CLK(CLK), .RST_N(RST_N), .WB_CYC_I(CYC),
        .WB_STB_I(STB), .WB_WE_I(WE), .WB_ADR_I(ADR), .WB_SEL_I(SEL),
        .WB_DAT_I(DAT_I), .WB_DAT_O(DAT_O), .WB_ACK_O(ACK),
        .SETUP_BEGIN(SB), .SETUP_DONE(SD), .STATUS_STAGE(SS),
        .IN_TOKEN(TOK), .IN_DONE(DONE), .IN_HOST_ACK(HACK),
        .IN_ERROR(HERR), .IN_RESP(RESP), .IN_PID_DATA1(PID1),
        .TX_RD(TX_RD), .TX_RD_DATA(TX_RD_DATA), .RX_WR(RX_WR),
        .RX_WR_DATA(RX_WR_DATA), .RX_FULL(RXF), .EP0_TX_INT(INT));
    etsf_host_model i_host (.clk(CLK), .in_resp(RESP), .in_pid_data1(PID1),
        .setup_begin(SB), .setup_done(SD), .status_stage(SS),
        .in_token(TOK), .in_done(DONE), .in_host_ack(HACK),
        .in_error(HERR));

    // Free-running 100 MHz clock
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : xs

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Classic cycle; held until ack is sampled, bounded wait
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] q);
        int n;
        @(posedge CLK);
        {CYC, STB, WE, ADR, SEL} <= {2'b11, w, a, 4'hF};
        DAT_I <= {24'h0, d};
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (ACK !== 1'b1 && n < 20);
        q = DAT_O;
        CYC <= 1'b0;
        STB <= 1'b0;
        if (n >= 20) begin
            n_fail++;
            tally_and_finish();
        end
    endtask : wb

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00, dummy);
        check(dummy, {24'h0, e});
    endtask : rd_chk

    // Status, flags, interrupt register and pin against the model
    task automatic chk_all();
        rd_chk(ETSF_OFS_TX_STATUS, {tog[0], 2'b0, stage[0], stl[0], nak[0],
               er[0], ak[0]});
        rd_chk(ETSF_OFS_TX_FLAGS, {4'h0, txq.size() == 0, txq.size() == 8,
               under[0], over[0]});
        rd_chk(ETSF_OFS_INT_STAT, {7'h0, irq[0]});
        check({31'h0, INT}, {31'h0, irq[0]});
    endtask : chk_all

    task automatic tx_push(input logic [7:0] d);
        wb(1'b1, ETSF_OFS_TX_DATA, d, dummy);
        if (txq.size() < 8) txq.push_back(d);
        else begin
            over = 1;
            irq = 1;
        end
    endtask : tx_push

    // Transmit logic pops one byte; an empty pop reads 00
    task automatic tx_pop();
        logic [7:0] e;
        @(posedge CLK) TX_RD <= 1'b1;
        @(posedge CLK) TX_RD <= 1'b0;
        @(posedge CLK);
        if (txq.size() == 0) begin
            e = 8'h00;
            under = 1;
            irq = 1;
        end else e = txq.pop_front();
        check({24'h0, TX_RD_DATA}, {24'h0, e});
    endtask : tx_pop

    // Recovery after under-run or over-run
    task automatic fifo_clear();
        wb(1'b1, ETSF_OFS_TX_CTRL, 8'h80, dummy);
        txq.delete();
        {under, over, irq, stall_ctl} = 4'h0;
        repeat (3) @(posedge CLK);
    endtask : fifo_clear

    task automatic setup();
        i_host.setup_txn();
        {ak, stage, stall_ctl} = 3'b000;
        tog = 1;
    endtask : setup

    // Whole IN transaction with answer, PID and status refresh
    task automatic in_full(input logic ha, input logic he, input int npop);
        etsf_resp_t r, e;
        logic p;
        e = stall_ctl ? ETSF_RESP_STALL :
            (txq.size() == 0 ? ETSF_RESP_NACK : ETSF_RESP_DATA);
        i_host.in_start(r, p);
        check({29'h0, r}, {29'h0, e});
        check({31'h0, p}, {31'h0, tog[0]});
        repeat (npop) tx_pop();
        i_host.in_end(ha, he);
        stl = (e == ETSF_RESP_STALL);
        nak = (e == ETSF_RESP_NACK);
        er = he;
        if (e == ETSF_RESP_DATA && ha && !he) begin
            tog ^= 1;
            ak = 1;
            irq = 1;
        end
    endtask : in_full

    // Main sequence
    initial begin
        {RST_N, CYC, STB, WE, TX_RD, RX_WR} = 6'h0;
        {ADR, RX_WR_DATA, SEL, DAT_I} = '0;
        {tog, stage, stl, nak, er, ak, irq} = '0;
        {under, over, stall_ctl} = '0;
        repeat (5) @(posedge CLK);
        RST_N <= 1'b1;
        chk_all();
        setup();
        in_full(1'b0, 1'b0, 0);
        chk_all();
        // Try to flip every read-only status bit; only ack may move
        wb(1'b1, ETSF_OFS_TX_STATUS, 8'h7A, dummy);
        chk_all();
        repeat (3) tx_push(xs());
        chk_all();
        in_full(1'b1, 1'b0, 3);
        chk_all();
        wb(1'b1, ETSF_OFS_TX_STATUS, 8'h00, dummy);
        {ak, irq} = 2'b00;
        chk_all();
        tx_push(xs());
        in_full(1'b1, 1'b1, 1);
        chk_all();
        wb(1'b1, ETSF_OFS_TX_CTRL, 8'h08, dummy);
        stall_ctl = 1;
        rd_chk(ETSF_OFS_TX_CTRL, 8'h08);
        in_full(1'b0, 1'b0, 0);
        i_host.stage_txn();
        stage = 1;
        chk_all();
        setup();
        in_full(1'b0, 1'b0, 0);
        chk_all();
        repeat (8) tx_push(xs());
        chk_all();
        tx_push(xs());
        chk_all();
        fifo_clear();
        rd_chk(ETSF_OFS_TX_CTRL, 8'h00);
        chk_all();
        tx_pop();
        chk_all();
        fifo_clear();
        chk_all();
        // Receive bytes fill the FIFO, then come back one per read
        repeat (8) begin
            @(posedge CLK) begin
                RX_WR <= 1'b1;
                RX_WR_DATA <= xs();
            end
            @(posedge CLK) RX_WR <= 1'b0;
            rxq.push_back(RX_WR_DATA);
        end
        // The full output is registered, so it shows a cycle late
        repeat (2) @(posedge CLK);
        check({31'h0, RXF}, 32'h1);
        repeat (8) rd_chk(ETSF_OFS_RX_DATA, rxq.pop_front());
        check({31'h0, RXF}, 32'h0);
        rd_chk(8'h20, 8'h00);
        tally_and_finish();
    end

endmodule : test_etsf_ep0_status
